// *** rtl/motion_status_pkg.sv ***
// Package of constants and types for the motion status register bank
// Summary of operation
// - At reset release the bank checks which servo amplifiers are present and stores one bit per axis, axes 1-16 in the low word and 17-32 in the high word.
// - An axis whose amplifier communication stops has its presence bit cleared.
// - After the first check the presence bits keep following every change of mounting state.
// - A presence bit is 1 only for an axis set as used whose amplifier is mounted, else 0.
// - An amplifier counts as not mounted when absent, when its control power is off or when its communication fails.
// - The network control status word shows 0 waiting for a command, -1 waiting to execute and -2 executing.
// - A test-mode request made while any axis is operating is refused and sets the test request error flag.
// - On a refused test-mode request the operating or stopped state of every axis is stored in two 16-bit words.
// - The watchdog cause word holds 1, 2, 4, 300, 303 or 304 for the six watchdog error kinds.
// - An operation cycle overrun stops all axes at once and refuses every operation start until reset.
// - Enabling a pulse generator assigned to an unused axis sets that generator's bit of the axis setting error word.
// - A servo program error at start sets the program setting error flag and stores the program number 0 to 4095.
// - A later failing program overwrites the stored program number with the newest one.
package motion_status_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int AXES = 32;
  localparam int HALF = 16;
  localparam int MPG_COUNT = 3;
  localparam int AXIS_NUM_W = 5;
  localparam int PROG_W = 12;
  localparam int ADDR_W = 8;

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_PRESENT_LO = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRESENT_HI = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BUSY_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_BUSY_HI = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_WD_CAUSE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MPG_ERR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PROG_NUM = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_NET_STATE = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_AXIS_USED = 8'h24;

  // Flag register bit positions
  localparam int FLAG_TEST_ERR = 0;
  localparam int FLAG_PROG_ERR = 1;
  localparam int FLAG_START_LOCK = 2;
  localparam int FLAG_CHECK_DONE = 3;

  // ************************************************************
  // Reset values and codes
  // ************************************************************
  localparam logic [AXES-1:0] AXIS_USED_RESET = 32'hffffffff;
  localparam logic [15:0] WD_CODE_NONE = 16'h0000;
  localparam logic [15:0] WD_CODE_SW1 = 16'h0001;
  localparam logic [15:0] WD_CODE_OVERRUN = 16'h0002;
  localparam logic [15:0] WD_CODE_WATCHDOG = 16'h0004;
  localparam logic [15:0] WD_CODE_SW3 = 16'h012c;
  localparam logic [15:0] WD_CODE_SW4 = 16'h012f;
  localparam logic [15:0] WD_CODE_REMOTE_IO = 16'h0130;
  localparam logic [15:0] NET_CODE_ACCEPT = 16'h0000;
  localparam logic [15:0] NET_CODE_EXEC_WAIT = 16'hffff;
  localparam logic [15:0] NET_CODE_EXECUTING = 16'hfffe;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int CHECK_TIME_NS = 800;
  localparam int CHECK_CYCLES = (CHECK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    WD_KIND_SW1,
    WD_KIND_OVERRUN,
    WD_KIND_WATCHDOG,
    WD_KIND_SW3,
    WD_KIND_SW4,
    WD_KIND_REMOTE_IO
  } wd_kind_t;

  typedef struct packed {
    logic [AXES-1:0] detect;
    logic [AXES-1:0] power_on;
    logic [AXES-1:0] comm_ok;
  } amp_status_t;

  typedef struct packed {
    logic cmd;
    logic exec_start;
    logic exec_done;
  } net_ctrl_t;

endpackage : motion_status_pkg

// *** rtl/presence_tracker.sv ***
// Servo amplifier presence tracker with start-up check phase
`timescale 1ns/1ps
module presence_tracker #(
  parameter int AXES = motion_status_pkg::AXES,
  parameter int CHECK_CYCLES = motion_status_pkg::CHECK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [AXES-1:0] axis_used,
  input wire logic [AXES-1:0] mounted,
  output logic [AXES-1:0] present,
  output logic check_done
);
  import motion_status_pkg::*;

  typedef enum logic {ST_CHECK, ST_RUN} track_state_t;

  localparam int CNT_W = $clog2(CHECK_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CHECK_CYCLES - 1);

  track_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;

  // ************************************************************
  // Check phase sequencing
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_CHECK;
      cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_CHECK: begin
          // Give the network time to settle before trusting any link
          if (cnt_reg == CNT_LAST) begin
            state_reg <= ST_RUN;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  // ************************************************************
  // Presence bits
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      present <= '0;
    end else if (state_reg == ST_RUN || cnt_reg == CNT_LAST) begin
      present <= axis_used & mounted;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_done <= 1'b0;
    end else begin
      check_done <= (state_reg == ST_RUN) || (cnt_reg == CNT_LAST);
    end
  end

endmodule : presence_tracker

// *** rtl/motion_status_registers.sv ***
// Motion status register bank with APB slave
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module motion_status_registers #(
  parameter int CHECK_CYCLES = motion_status_pkg::CHECK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [motion_status_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire motion_status_pkg::amp_status_t amp_status,
  input wire motion_status_pkg::net_ctrl_t net_ctrl,
  input wire logic [motion_status_pkg::AXES-1:0] axis_busy,
  input wire logic test_req,
  output logic test_grant,
  output logic test_reject,
  input wire logic wd_event,
  input wire motion_status_pkg::wd_kind_t wd_kind,
  output logic stop_all,
  input wire logic start_req,
  output logic start_grant,
  input wire logic [motion_status_pkg::MPG_COUNT-1:0] mpg_enable,
  input wire logic [motion_status_pkg::MPG_COUNT-1:0][motion_status_pkg::AXIS_NUM_W-1:0] mpg_axis,
  input wire logic prog_err,
  input wire logic [motion_status_pkg::PROG_W-1:0] prog_num,
  output logic [motion_status_pkg::AXES-1:0] present_axes
);
  import motion_status_pkg::*;

  typedef enum logic [1:0] {NET_ACCEPT, NET_EXEC_WAIT, NET_EXECUTING} net_state_t;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [15:0] wd_code(input wd_kind_t kind);
    logic [15:0] code;
    code = WD_CODE_NONE;
    unique case (kind)
      WD_KIND_SW1: code = WD_CODE_SW1;
      WD_KIND_OVERRUN: code = WD_CODE_OVERRUN;
      WD_KIND_WATCHDOG: code = WD_CODE_WATCHDOG;
      WD_KIND_SW3: code = WD_CODE_SW3;
      WD_KIND_SW4: code = WD_CODE_SW4;
      WD_KIND_REMOTE_IO: code = WD_CODE_REMOTE_IO;
      default: code = WD_CODE_NONE;
    endcase
    return code;
  endfunction : wd_code

  function automatic logic [31:0] zext16(input logic [15:0] v);
    return {16'h0000, v};
  endfunction : zext16

  // ************************************************************
  // Storage
  // ************************************************************
  logic [AXES-1:0] axis_used_reg;
  logic [AXES-1:0] busy_snap_reg;
  logic [15:0] wd_cause_reg;
  logic start_lock_reg;
  logic [MPG_COUNT-1:0] mpg_err_reg;
  logic [MPG_COUNT-1:0] mpg_enable_prev_reg;
  logic [15:0] prog_num_reg;
  logic test_err_reg;
  logic prog_err_flag_reg;
  net_state_t net_state_reg;
  logic [AXES-1:0] mounted;
  logic check_done;
  logic [AXES-1:0] present;
  logic setup_phase;
  logic wr_commit;
  logic [31:0] rd_next;
  logic err_next;
  logic [15:0] net_code;
  logic test_refused;
  logic overrun_now;
  logic flags_clr_wr;
  logic mpg_clr_wr;
  logic [MPG_COUNT-1:0] mpg_set;

  // ************************************************************
  // Amplifier presence
  // ************************************************************
  // Any of the three faults drops the axis, so a cable fault looks like an absent unit
  assign mounted = amp_status.detect & amp_status.power_on & amp_status.comm_ok;

  presence_tracker #(
    .AXES(AXES),
    .CHECK_CYCLES(CHECK_CYCLES)
  ) u_presence (
    .pclk(pclk),
    .presetn(presetn),
    .axis_used(axis_used_reg),
    .mounted(mounted),
    .present(present),
    .check_done(check_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      present_axes <= '0;
    end else begin
      present_axes <= present;
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  assign setup_phase = psel && !penable;
  assign wr_commit = psel && penable && pready && pwrite && !pslverr;
  assign flags_clr_wr = wr_commit && (paddr == OFS_FLAGS);
  assign mpg_clr_wr = wr_commit && (paddr == OFS_MPG_ERR);

  always_comb begin
    rd_next = 32'h00000000;
    err_next = 1'b0;
    unique case (paddr)
      OFS_PRESENT_LO: rd_next = zext16(present[HALF-1:0]);
      OFS_PRESENT_HI: rd_next = zext16(present[AXES-1:HALF]);
      OFS_BUSY_LO: rd_next = zext16(busy_snap_reg[HALF-1:0]);
      OFS_BUSY_HI: rd_next = zext16(busy_snap_reg[AXES-1:HALF]);
      OFS_WD_CAUSE: rd_next = zext16(wd_cause_reg);
      OFS_MPG_ERR: rd_next = {29'h00000000, mpg_err_reg};
      OFS_PROG_NUM: rd_next = zext16(prog_num_reg);
      OFS_NET_STATE: rd_next = zext16(net_code);
      OFS_FLAGS: begin
        rd_next[FLAG_TEST_ERR] = test_err_reg;
        rd_next[FLAG_PROG_ERR] = prog_err_flag_reg;
        rd_next[FLAG_START_LOCK] = start_lock_reg;
        rd_next[FLAG_CHECK_DONE] = check_done;
      end
      OFS_AXIS_USED: rd_next = axis_used_reg;
      default: err_next = 1'b1;
    endcase
  end

  // Answer one cycle after setup so every bus output comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup_phase) begin
      pready <= 1'b1;
      pslverr <= err_next;
      prdata <= pwrite ? 32'h00000000 : rd_next;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      axis_used_reg <= AXIS_USED_RESET;
    end else if (wr_commit && paddr == OFS_AXIS_USED) begin
      axis_used_reg <= pwdata;
    end
  end

  // ************************************************************
  // Network control status
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_state_reg <= NET_ACCEPT;
    end else begin
      unique case (net_state_reg)
        NET_ACCEPT: if (net_ctrl.cmd) begin
          net_state_reg <= NET_EXEC_WAIT;
        end
        NET_EXEC_WAIT: if (net_ctrl.exec_start) begin
          net_state_reg <= NET_EXECUTING;
        end
        NET_EXECUTING: if (net_ctrl.exec_done) begin
          net_state_reg <= NET_ACCEPT;
        end
      endcase
    end
  end

  always_comb begin
    net_code = NET_CODE_ACCEPT;
    unique case (net_state_reg)
      NET_ACCEPT: net_code = NET_CODE_ACCEPT;
      NET_EXEC_WAIT: net_code = NET_CODE_EXEC_WAIT;
      NET_EXECUTING: net_code = NET_CODE_EXECUTING;
      default: net_code = NET_CODE_ACCEPT;
    endcase
  end

  // ************************************************************
  // Test-mode request
  // ************************************************************
  assign test_refused = test_req && (|axis_busy);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_grant <= 1'b0;
      test_reject <= 1'b0;
    end else begin
      test_grant <= test_req && !(|axis_busy);
      test_reject <= test_refused;
    end
  end

  // A new refusal wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_err_reg <= 1'b0;
    end else if (test_refused) begin
      test_err_reg <= 1'b1;
    end else if (flags_clr_wr && pwdata[FLAG_TEST_ERR]) begin
      test_err_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_snap_reg <= '0;
    end else if (test_refused) begin
      busy_snap_reg <= axis_busy;
    end
  end

  // ************************************************************
  // Watchdog cause and start lock
  // ************************************************************
  assign overrun_now = wd_event && (wd_kind == WD_KIND_OVERRUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cause_reg <= WD_CODE_NONE;
    end else if (wd_event) begin
      wd_cause_reg <= wd_code(wd_kind);
    end
  end

  // Only reset releases the lock; software has no way to clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_lock_reg <= 1'b0;
      stop_all <= 1'b0;
    end else if (overrun_now) begin
      start_lock_reg <= 1'b1;
      stop_all <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_grant <= 1'b0;
    end else begin
      start_grant <= start_req && !start_lock_reg && !overrun_now;
    end
  end

  // ************************************************************
  // Pulse generator axis check
  // ************************************************************
  always_comb begin
    mpg_set = '0;
    for (int i = 0; i < MPG_COUNT; i++) begin
      mpg_set[i] = mpg_enable[i] && !mpg_enable_prev_reg[i] && !axis_used_reg[mpg_axis[i]];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mpg_enable_prev_reg <= '0;
    end else begin
      mpg_enable_prev_reg <= mpg_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mpg_err_reg <= '0;
    end else if (mpg_clr_wr) begin
      mpg_err_reg <= (mpg_err_reg & ~pwdata[MPG_COUNT-1:0]) | mpg_set;
    end else begin
      mpg_err_reg <= mpg_err_reg | mpg_set;
    end
  end

  // ************************************************************
  // Servo program error
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_err_flag_reg <= 1'b0;
    end else if (prog_err) begin
      prog_err_flag_reg <= 1'b1;
    end else if (flags_clr_wr && pwdata[FLAG_PROG_ERR]) begin
      prog_err_flag_reg <= 1'b0;
    end
  end

  // Newest failure always replaces the held number
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_num_reg <= 16'h0000;
    end else if (prog_err) begin
      prog_num_reg <= {4'h0, prog_num};
    end
  end

endmodule : motion_status_registers

// *** sim/amp_model.sv ***
// Behavioural servo amplifier set on the far side of the servo network
`timescale 1ns/1ps
module amp_model (
  input wire logic pclk,
  input wire logic [31:0] fit,
  input wire logic [31:0] off,
  input wire logic [31:0] cut,
  output motion_status_pkg::amp_status_t amp_status
);
  import motion_status_pkg::*;
  // An absent unit has neither power nor a link, so it never looks half present
  always_ff @(posedge pclk) begin
    amp_status.detect <= fit;
    amp_status.power_on <= fit & ~off;
    amp_status.comm_ok <= fit & ~off & ~cut;
  end
endmodule : amp_model

// *** sim/motion_status_checker.sv ***
// Concurrent checks on the ports of the motion status register bank
`timescale 1ns/1ps
module motion_status_checker #(
  parameter int CHECK_CYCLES = motion_status_pkg::CHECK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire motion_status_pkg::amp_status_t amp_status,
  input wire logic [motion_status_pkg::AXES-1:0] axis_busy,
  input wire logic test_req,
  input wire logic test_grant,
  input wire logic test_reject,
  input wire logic wd_event,
  input wire motion_status_pkg::wd_kind_t wd_kind,
  input wire logic stop_all,
  input wire logic start_req,
  input wire logic start_grant,
  input wire logic [motion_status_pkg::AXES-1:0] present_axes
);
  import motion_status_pkg::*;
  // ************************************************************
  // Helpers
  // ************************************************************
  logic [31:0] mnt;
  logic ovr;
  assign mnt = amp_status.detect & amp_status.power_on & amp_status.comm_ok;
  assign ovr = wd_event && (wd_kind == WD_KIND_OVERRUN);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ************************************************************
  // Assertions
  // ************************************************************
  // Two cycles of history, since the bit passes two registers
  only_mounted_a: assert property ((present_axes & ~$past(mnt) & ~$past(mnt, 2)) == 32'h0)
    else $error("presence bit set for an unmounted axis");
  link_loss_a: assert property ($fell(amp_status.comm_ok[2]) |-> ##[1:3] !present_axes[2])
    else $error("presence bit kept after link loss");
  reject_busy_a: assert property (test_req && (|axis_busy) |=> test_reject && !test_grant)
    else $error("busy test request not refused");
  grant_idle_a: assert property (test_req && !(|axis_busy) |=> test_grant && !test_reject)
    else $error("idle test request not granted");
  overrun_stop_a: assert property (ovr |=> stop_all)
    else $error("overrun did not stop axes");
  stop_hold_a: assert property (stop_all |=> stop_all)
    else $error("stop released before reset");
  start_lock_a: assert property (stop_all || ovr |=> !start_grant)
    else $error("start granted after overrun");
  start_ok_a: assert property (start_req && !stop_all && !ovr |=> start_grant)
    else $error("start refused without overrun");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  cover property (test_req && (|axis_busy));
  cover property ($rose(stop_all));
  cover property (pslverr);
endmodule : motion_status_checker
bind motion_status_registers motion_status_checker #(.CHECK_CYCLES(CHECK_CYCLES)) chk_inst (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .amp_status, .axis_busy, .test_req,
  .test_grant, .test_reject, .wd_event, .wd_kind, .stop_all, .start_req, .start_grant,
  .present_axes);

// *** sim/testbench.sv ***
// Self-checking bench for the motion status register bank
`timescale 1ns/1ps
module testbench;
  import motion_status_pkg::*;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] fit = 32'h00038005;
  logic [31:0] off = 32'h0;
  logic [31:0] cut = 32'h0;
  logic [31:0] axis_busy = 32'h0;
  logic [31:0] prdata;
  logic [31:0] present_axes;
  logic pready, pslverr, test_grant, test_reject, stop_all, start_grant;
  logic test_req = 1'h0;
  logic wd_event = 1'h0;
  logic start_req = 1'h0;
  logic prog_err = 1'h0;
  amp_status_t amp_status;
  net_ctrl_t net_ctrl = 3'h0;
  wd_kind_t wd_kind = WD_KIND_SW1;
  logic [MPG_COUNT-1:0] mpg_enable = 3'h0;
  logic [MPG_COUNT-1:0][AXIS_NUM_W-1:0] mpg_axis = 15'h0;
  logic [PROG_W-1:0] prog_num = 12'h000;
  int errors = 0;
  int n_checks = 0;
  always #4 pclk = ~pclk;
  amp_model amp_model_inst (.pclk, .fit, .off, .cut, .amp_status);
  // Short settle count keeps the start-up check quick
  motion_status_registers #(.CHECK_CYCLES(2)) motion_status_registers_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .amp_status, .net_ctrl, .axis_busy, .test_req, .test_grant, .test_reject, .wd_event,
    .wd_kind, .stop_all, .start_req, .start_grant, .mpg_enable, .mpg_axis, .prog_err,
    .prog_num, .present_axes);
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // No cycle count is assumed; only the bench watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'h0, a, 32'h0, r, e);
    chk(nm, exp, r);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask : wr
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_present;
    logic [31:0] r;
    logic e;
    tick(4);
    rd(OFS_PRESENT_LO, 32'h8005, "present_lo");
    rd(OFS_PRESENT_HI, 32'h0003, "present_hi");
    chk("present_axes", 32'h00038005, present_axes);
    wr(OFS_PRESENT_LO, 32'h0);
    apb(1'h0, 8'h40, 32'h0, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    wr(OFS_AXIS_USED, 32'hfffffffe);
    tick(3);
    rd(OFS_PRESENT_LO, 32'h8004, "unused_lo");
    wr(OFS_AXIS_USED, 32'hffffffff);
    cut <= 32'h4;
    off <= 32'h8000;
    fit <= 32'h00038015;
    tick(4);
    rd(OFS_PRESENT_LO, 32'h0011, "changed_lo");
    $display("test present done");
  endtask : t_present
  task automatic t_test;
    axis_busy <= 32'h00010005;
    test_req <= 1'h1;
    tick(1);
    test_req <= 1'h0;
    tick(1);
    chk("test_reject", 32'h1, {31'h0, test_reject});
    rd(OFS_BUSY_LO, 32'h0005, "busy_lo");
    rd(OFS_BUSY_HI, 32'h0001, "busy_hi");
    rd(OFS_FLAGS, 32'h9, "flags_test");
    wr(OFS_FLAGS, 32'h1);
    axis_busy <= 32'h0;
    test_req <= 1'h1;
    tick(1);
    test_req <= 1'h0;
    tick(1);
    chk("test_grant", 32'h1, {31'h0, test_grant});
    $display("test mode done");
  endtask : t_test
  task automatic t_net;
    logic [2:0] p [4] = '{3'h2, 3'h4, 3'h2, 3'h1};
    logic [31:0] x [4] = '{32'h0, 32'hffff, 32'hfffe, 32'h0};
    for (int i = 0; i < 4; i++) begin
      net_ctrl <= p[i];
      tick(1);
      net_ctrl <= 3'h0;
      rd(OFS_NET_STATE, x[i], "net_state");
    end
    $display("test net done");
  endtask : t_net
  task automatic t_mpg;
    wr(OFS_AXIS_USED, 32'hffffffdf);
    mpg_axis <= 15'h00a0;
    tick(1);
    mpg_enable <= 3'h3;
    tick(2);
    rd(OFS_MPG_ERR, 32'h2, "mpg_err");
    wr(OFS_MPG_ERR, 32'h2);
    rd(OFS_MPG_ERR, 32'h0, "mpg_clear");
    wr(OFS_AXIS_USED, 32'hffffffff);
    $display("test mpg done");
  endtask : t_mpg
  task automatic t_prog;
    prog_num <= 12'h007;
    prog_err <= 1'h1;
    tick(1);
    prog_err <= 1'h0;
    rd(OFS_PROG_NUM, 32'h007, "prog_num");
    rd(OFS_FLAGS, 32'ha, "flags_prog");
    wr(OFS_FLAGS, 32'h2);
    rd(OFS_FLAGS, 32'h8, "flags_clear");
    prog_num <= 12'h123;
    prog_err <= 1'h1;
    tick(1);
    prog_num <= 12'hfff;
    tick(1);
    prog_err <= 1'h0;
    rd(OFS_PROG_NUM, 32'hfff, "prog_newest");
    $display("test prog done");
  endtask : t_prog
  // Overrun runs last because its start lock lasts until reset
  task automatic t_wd;
    wd_kind_t k [6] = '{WD_KIND_SW1, WD_KIND_WATCHDOG, WD_KIND_SW3, WD_KIND_SW4,
                        WD_KIND_REMOTE_IO, WD_KIND_OVERRUN};
    logic [31:0] c [6] = '{32'h1, 32'h4, 32'h12c, 32'h12f, 32'h130, 32'h2};
    for (int i = 0; i < 6; i++) begin
      start_req <= 1'h1;
      tick(1);
      start_req <= 1'h0;
      tick(1);
      chk("start_grant", {31'h0, i < 6}, {31'h0, start_grant});
      wd_kind <= k[i];
      wd_event <= 1'h1;
      tick(1);
      wd_event <= 1'h0;
      rd(OFS_WD_CAUSE, c[i], "wd_cause");
    end
    chk("stop_all", 32'h1, {31'h0, stop_all});
    start_req <= 1'h1;
    tick(1);
    start_req <= 1'h0;
    tick(1);
    chk("locked_start", 32'h0, {31'h0, start_grant});
    $display("test watchdog done");
  endtask : t_wd
  // Only a system reset lifts the overrun lock and reruns the presence check
  task automatic t_reset;
    presetn <= 1'h0;
    tick(2);
    chk("reset_stop", 32'h0, {31'h0, stop_all});
    presetn <= 1'h1;
    tick(4);
    rd(OFS_PRESENT_LO, 32'h0011, "reset_present_lo");
    start_req <= 1'h1;
    tick(1);
    start_req <= 1'h0;
    tick(1);
    chk("reset_start", 32'h1, {31'h0, start_grant});
    $display("test reset done");
  endtask : t_reset
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #160000;
    errors++;
    tally_and_finish;
  end
  initial begin
    tick(12);
    presetn <= 1'h1;
    t_present;
    t_test;
    t_net;
    t_mpg;
    t_prog;
    t_wd;
    t_reset;
    tally_and_finish;
  end
endmodule : testbench
